/* File: inc/seeb_pkg.sv */
// constants, timing and state encoding for the serial eeprom bus slave
// assumes a single 10 MHz core clock shared by every module of the block
package seeb_pkg;
    localparam int          CLOCK_NS      = 100;
    localparam int          SPIKE_NS      = 50;
    // least filter time: round up, never below one cycle
    localparam int          FILT_RAW      = (SPIKE_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int          FILT_CYCLES   = (FILT_RAW < 1) ? 1 : FILT_RAW;
    localparam int          TWC_MS        = 5;
    // longest time: round down
    localparam int          TWC_CYCLES    = (TWC_MS * 1000000) / CLOCK_NS;
    localparam logic [3:0]  DEV_CODE      = 4'hA;
    localparam int          PAGE_BYTES    = 16;
    localparam int          ARRAY_BYTES   = 256;
    localparam int          PROT_BIT      = 7;
    localparam int          LINE_SCL      = 0;
    localparam int          LINE_SDA      = 1;
    localparam logic [1:0]  LINE_RST      = 2'h3;
    localparam logic [7:0]  PTR_RST       = 8'h00;
    localparam logic [4:0]  COMMIT_LAST   = 5'h10;
    localparam logic [2:0]  BIT_LAST      = 3'h7;
    typedef enum logic [2:0] {
        S_IDLE,
        S_CTRL,
        S_ADDR,
        S_DATA,
        S_IGNORE,
        S_BUSY
    } seeb_state_t;
    typedef enum logic [1:0] {
        ACK_NONE,
        ACK_WAIT,
        ACK_DRIVE
    } seeb_ack_t;
endpackage

/* File: inc/seeb_mem_if.sv */
// write and registered-read port of a small byte memory
// assumes one clock; the controller drives, the memory answers
`timescale 1ns/1ps
`default_nettype none
interface seeb_mem_if #(parameter int AW = 4);
    logic          we;
    logic [AW-1:0] waddr;
    logic [7:0]    wdata;
    logic [AW-1:0] raddr;
    logic [7:0]    rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

/* File: hdl/seeb_mem.sv */
// byte memory with one write port and a registered read port
// assumes address and data are stable on the clock edge
`timescale 1ns/1ps
`default_nettype none
module seeb_mem #(
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic  i_clock,
    input  wire logic  i_rst,
    seeb_mem_if.mem    port
);
    import seeb_pkg::*;

    typedef struct packed {
        logic [DEPTH-1:0][7:0] cells;
        logic [7:0]            rdata;
    } seeb_mem_state_t;

    seeb_mem_state_t s;
    seeb_mem_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.rdata = s.cells[port.raddr];
        if (port.we) begin
            next_s.cells[port.waddr] = port.wdata;
        end
    end

    // erased cells read as all ones
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            s <= '1;
        end else begin
            s <= next_s;
        end
    end

    assign port.rdata = s.rdata;
endmodule
`default_nettype wire

/* File: hdl/seeb_line_filter.sv */
// synchroniser and deglitch filter for both bus lines, plus bus events
// assumes raw pin levels; line outputs are registered levels, event outputs registered one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module seeb_line_filter (
    input  wire logic i_clock,
    input  wire logic i_rst,
    input  wire logic i_scl,
    input  wire logic i_sda,
    output var  logic o_scl,
    output var  logic o_sda,
    output var  logic o_start,
    output var  logic o_stop,
    output var  logic o_scl_rise,
    output var  logic o_scl_fall
);
    import seeb_pkg::*;

    typedef struct packed {
        logic [1:0]      sync1;
        logic [1:0]      sync2;
        logic [1:0][1:0] cnt;
        logic [1:0]      level;
        logic            start;
        logic            stop;
        logic            rise;
        logic            fall;
    } seeb_filt_t;

    seeb_filt_t s;
    seeb_filt_t next_s;

    always_comb begin
        next_s = s;
        next_s.sync1 = {i_sda, i_scl};
        next_s.sync2 = s.sync1;
        // [R24] spike rejection
        for (int i = 0; i < 2; i++) begin
            if (s.sync2[i] == s.level[i]) begin
                next_s.cnt[i] = 2'h0;
            end else if (s.cnt[i] == 2'(FILT_CYCLES)) begin
                next_s.level[i] = s.sync2[i];
                next_s.cnt[i]   = 2'h0;
            end else begin
                next_s.cnt[i] = 2'(s.cnt[i] + 2'h1);
            end
        end
        // [R3] start detect
        next_s.start = s.level[LINE_SCL] & next_s.level[LINE_SCL]
                     & s.level[LINE_SDA] & ~next_s.level[LINE_SDA];
        // [R4] stop detect
        next_s.stop  = s.level[LINE_SCL] & next_s.level[LINE_SCL]
                     & ~s.level[LINE_SDA] & next_s.level[LINE_SDA];
        next_s.rise  = ~s.level[LINE_SCL] & next_s.level[LINE_SCL];
        next_s.fall  = s.level[LINE_SCL] & ~next_s.level[LINE_SCL];
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            s       <= '0;
            s.sync1 <= LINE_RST;
            s.sync2 <= LINE_RST;
            s.level <= LINE_RST;
        end else begin
            s <= next_s;
        end
    end

    assign o_scl      = s.level[LINE_SCL];
    assign o_sda      = s.level[LINE_SDA];
    assign o_start    = s.start;
    assign o_stop     = s.stop;
    assign o_scl_rise = s.rise;
    assign o_scl_fall = s.fall;
endmodule
`default_nettype wire

/* File: hdl/seeb_slave.sv */
// two-wire bus slave front end of a 256-byte eeprom with page write
// assumes an external pull-up on the data line and a master driving the clock
// Operation
// [R1] select only when address bits of control byte equal strap pins
// [R2] write-protect high blocks writes to upper half; low allows all
// [R3] data falling while clock high is a start; commands begin with it
// [R4] data rising while clock high is a stop; operations end with it
// [R5] one bit per clock pulse, sampled on the clock high phase
// [R6] bus idle when both lines high; transfers start only then
// [R7] addressed receiver pulls data low through ninth clock high phase
// [R8] master gives a ninth clock pulse per byte for acknowledge
// [R9] no acknowledge at all while an internal programming cycle runs
// [R10] master ends a read with no acknowledge; slave releases data line
// [R11] control byte: four-bit device code, three select bits, direction bit
// [R12] direction bit one means read, zero means write
// [R13] acknowledge control byte only when code and select bits match
// [R14] write: byte after control loads pointer, acked; data bytes acked
// [R15] stop after write data starts write cycle; bus ignored until done
// [R16] protected writes still acked and timed, but memory unchanged
// [R17] up to fifteen more bytes held in page buffer, committed after stop
// [R18] each data byte increments only the low four pointer bits
// [R19] more than sixteen bytes wrap in page; last sixteen kept
// [R20] host avoids page writes crossing a page boundary
// [R21] select bits extend address; no sequential access into other devices
// [R22] internal write cycle lasts at most five milliseconds
// [R23] data line only pulled low or released, never driven high
// [R24] both lines synchronised and deglitched before edge detection
// [R25] start or stop mid-byte abandons it; partial bytes never buffered
`timescale 1ns/1ps
`default_nettype none
module seeb_slave #(
    parameter int TWC_CYCLES_P = seeb_pkg::TWC_CYCLES
) (
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output var  logic       o_sda_out,
    output var  logic       o_sda_oe,
    input  wire logic       i_chip_select_pin_0,
    input  wire logic       i_chip_select_pin_1,
    input  wire logic       i_chip_select_pin_2,
    input  wire logic       i_write_protect,
    input  wire logic [7:0] i_peek_addr,
    output var  logic [7:0] o_peek_data,
    output var  logic       o_busy,
    output var  logic [7:0] o_addr_ptr
);
    import seeb_pkg::*;

    typedef struct packed {
        seeb_state_t state;
        seeb_ack_t   ack_stage;
        logic [7:0]  shreg;
        logic [2:0]  bitcnt;
        logic        ack_now;
        logic        sda_oe;
        logic        sda_out;
        logic [7:0]  ptr;
        logic [15:0] valid;
        logic        have_data;
        logic        wp_hold;
        logic [15:0] timer;
        logic [4:0]  commit_cnt;
        logic        busy;
    } seeb_slave_t;

    seeb_slave_t s;
    seeb_slave_t next_s;

    logic f_sda;
    logic f_start;
    logic f_stop;
    logic f_rise;
    logic f_fall;

    seeb_mem_if #(.AW(4)) pbuf ();
    seeb_mem_if #(.AW(8)) arr ();

    seeb_line_filter u_filter (
        .i_clock    (i_clock),
        .i_rst      (i_rst),
        .i_scl      (i_scl),
        .i_sda      (i_sda),
        .o_scl      (),
        .o_sda      (f_sda),
        .o_start    (f_start),
        .o_stop     (f_stop),
        .o_scl_rise (f_rise),
        .o_scl_fall (f_fall)
    );

    seeb_mem #(.DEPTH(PAGE_BYTES), .AW(4)) u_page_buf (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .port    (pbuf.mem)
    );

    seeb_mem #(.DEPTH(ARRAY_BYTES), .AW(8)) u_array (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .port    (arr.mem)
    );

    logic [7:0] shifted;
    logic [2:0] pins;
    logic       match;
    logic [3:0] commit_idx;
    logic       commit_ok;

    always_comb begin
        next_s     = s;
        // [R5] sample on clock rise
        shifted    = {s.shreg[6:0], f_sda};
        pins       = {i_chip_select_pin_2, i_chip_select_pin_1, i_chip_select_pin_0};
        // [R11] control byte layout
        // [R1] strap compare
        match      = (shifted[7:4] == DEV_CODE) && (shifted[3:1] == pins);
        commit_idx = 4'(s.commit_cnt - 5'h01);
        // [R2] upper half protected when write-protect is high
        commit_ok  = s.valid[commit_idx] && !(s.wp_hold && s.ptr[PROT_BIT]);

        pbuf.we    = 1'b0;
        pbuf.waddr = s.ptr[3:0];
        pbuf.wdata = shifted;
        pbuf.raddr = s.commit_cnt[3:0];
        arr.we     = 1'b0;
        // [R21] commit never leaves this device's page
        arr.waddr  = {s.ptr[7:4], commit_idx};
        arr.wdata  = pbuf.rdata;
        arr.raddr  = i_peek_addr;

        if (s.state == S_BUSY) begin
            // [R9] bus ignored, line stays released while busy
            next_s.sda_oe = 1'b0;
            // buffer read data lag one cycle behind the read address
            if (s.commit_cnt != 5'h00 && s.commit_cnt <= COMMIT_LAST) begin
                // [R16] protected bytes skipped, cycle still timed
                arr.we = commit_ok;
            end
            if (s.commit_cnt <= COMMIT_LAST) begin
                next_s.commit_cnt = 5'(s.commit_cnt + 5'h01);
            end
            // [R22] write cycle length
            if (s.timer == 16'(TWC_CYCLES_P - 1)) begin
                next_s.state = S_IDLE;
                next_s.busy  = 1'b0;
                next_s.timer = 16'h0000;
            end else begin
                next_s.timer = 16'(s.timer + 16'h0001);
            end
        end else if (f_start) begin
            // [R3] start (also repeated start) opens a control byte
            // [R25] partial byte dropped
            next_s.state     = S_CTRL;
            next_s.bitcnt    = 3'h0;
            next_s.ack_stage = ACK_NONE;
            next_s.sda_oe    = 1'b0;
        end else if (f_stop) begin
            // [R4] stop ends the operation
            // [R25] partial byte dropped
            next_s.bitcnt    = 3'h0;
            next_s.ack_stage = ACK_NONE;
            next_s.sda_oe    = 1'b0;
            // [R15] stop after data launches the write cycle
            if (s.state == S_DATA && s.have_data) begin
                next_s.state      = S_BUSY;
                next_s.busy       = 1'b1;
                next_s.timer      = 16'h0000;
                next_s.commit_cnt = 5'h00;
                next_s.wp_hold    = i_write_protect;
            end else begin
                // [R6] back to idle; only a start leaves it
                next_s.state = S_IDLE;
            end
        end else if (s.state != S_IDLE) begin
            if (f_rise && s.ack_stage == ACK_NONE) begin
                next_s.shreg  = shifted;
                next_s.bitcnt = 3'(s.bitcnt + 3'h1);
                if (s.bitcnt == BIT_LAST) begin
                    next_s.ack_stage = ACK_WAIT;
                    unique case (s.state)
                        S_CTRL: begin
                            // [R13] acknowledge only on full match
                            next_s.ack_now   = match;
                            next_s.valid     = 16'h0000;
                            next_s.have_data = 1'b0;
                            // [R12] direction bit; reads are not served here
                            // [R10] read path keeps the line released
                            if (match && !shifted[0]) begin
                                next_s.state = S_ADDR;
                            end else begin
                                next_s.state = S_IGNORE;
                            end
                        end
                        S_ADDR: begin
                            // [R14] word address loads the pointer
                            next_s.ptr     = shifted;
                            next_s.ack_now = 1'b1;
                            next_s.state   = S_DATA;
                        end
                        S_DATA: begin
                            // [R17] byte held in page buffer
                            // [R19] wrapped slots overwrite older bytes
                            pbuf.we                 = 1'b1;
                            next_s.valid[s.ptr[3:0]] = 1'b1;
                            next_s.have_data        = 1'b1;
                            // [R18] only low nibble advances
                            next_s.ptr[3:0]         = 4'(s.ptr[3:0] + 4'h1);
                            // [R14] data byte acknowledged
                            next_s.ack_now          = 1'b1;
                        end
                        S_IGNORE: begin
                            next_s.ack_now = 1'b0;
                        end
                        default: begin
                            next_s.ack_now = 1'b0;
                        end
                    endcase
                end
            end else if (f_fall && s.ack_stage == ACK_WAIT) begin
                // [R7] hold low across the ninth clock high phase
                // [R8] ninth pulse carries the acknowledge
                next_s.ack_stage = ACK_DRIVE;
                next_s.sda_oe    = s.ack_now;
            end else if (f_fall && s.ack_stage == ACK_DRIVE) begin
                next_s.ack_stage = ACK_NONE;
                next_s.sda_oe    = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            s     <= '0;
            s.ptr <= PTR_RST;
        end else begin
            s <= next_s;
        end
    end

    // [R23] open drain: the driven level is always low
    assign o_sda_out   = s.sda_out;
    assign o_sda_oe    = s.sda_oe;
    assign o_busy      = s.busy;
    assign o_addr_ptr  = s.ptr;
    assign o_peek_data = arr.rdata;
endmodule
`default_nettype wire

/* File: dv/seeb_slave_sva.sv */
// assertions on the pins of the eeprom bus slave
// assumes bench bus phases of eight core cycles or more
`timescale 1ns/1ps
`default_nettype none
module seeb_slave_sva #(
    parameter int TWC_CYCLES_P = 100
) (
    input wire logic       i_clock,
    input wire logic       i_rst,
    input wire logic       i_scl,
    input wire logic       i_sda,
    input wire logic       o_sda_out,
    input wire logic       o_sda_oe,
    input wire logic       i_chip_select_pin_0,
    input wire logic       i_chip_select_pin_1,
    input wire logic       i_chip_select_pin_2,
    input wire logic       i_write_protect,
    input wire logic [7:0] i_peek_addr,
    input wire logic [7:0] o_peek_data,
    input wire logic       o_busy,
    input wire logic [7:0] o_addr_ptr
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);
    // length of the running write cycle
    int busy_cnt;
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= o_busy ? busy_cnt + 1 : 0;
        end
    end
    a_never_high: assert property (o_sda_out == 1'b0)
        else $error("data line driven high");
    a_busy_no_ack: assert property (o_busy |-> !o_sda_oe)
        else $error("acknowledge during write cycle");
    a_ack_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
        else $error("data drive changed with clock high");
    a_ack_holds: assert property ($rose(o_sda_oe) |-> o_sda_oe[*8])
        else $error("acknowledge too short");
    a_ack_released: assert property ($rose(o_sda_oe) |-> ##[8:60] !o_sda_oe)
        else $error("acknowledge not released");
    a_busy_at_stop: assert property ($rose(o_busy) |-> i_scl && i_sda)
        else $error("write cycle without idle lines");
    a_busy_held: assert property ($rose(o_busy) |-> o_busy[*8])
        else $error("write cycle collapsed");
    a_busy_bound: assert property (busy_cnt <= TWC_CYCLES_P)
        else $error("write cycle overran");
    cover property ($rose(o_sda_oe));
    cover property ($fell(o_busy));
    cover property (o_busy && i_write_protect);
endmodule
bind seeb_slave seeb_slave_sva #(.TWC_CYCLES_P(TWC_CYCLES_P)) i_seeb_slave_sva (
    .i_clock(i_clock), .i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda),
    .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
    .i_chip_select_pin_0(i_chip_select_pin_0), .i_chip_select_pin_1(i_chip_select_pin_1),
    .i_chip_select_pin_2(i_chip_select_pin_2), .i_write_protect(i_write_protect),
    .i_peek_addr(i_peek_addr), .o_peek_data(o_peek_data), .o_busy(o_busy), .o_addr_ptr(o_addr_ptr));
`default_nettype wire

/* File: dv/seeb_master_model.sv */
// two-wire bus master model: clock and open-drain data enable
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ps
`default_nettype none
module seeb_master_model (
    input  wire logic i_clock,
    input  wire logic i_sda,
    output var  logic o_scl,
    output var  logic o_sda_oe
);
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end
    // eight cycles a phase, well above the filter delay
    task automatic pause();
        repeat (8) @(posedge i_clock);
    endtask
    task automatic bus_start();
        o_sda_oe <= 1'b0;
        pause();
        o_scl <= 1'b1;
        pause();
        o_sda_oe <= 1'b1;
        pause();
        o_scl <= 1'b0;
        pause();
    endtask
    task automatic bus_stop();
        o_sda_oe <= 1'b1;
        pause();
        o_scl <= 1'b1;
        pause();
        o_sda_oe <= 1'b0;
        pause();
    endtask
    // data moves only with clock low
    task automatic bus_bit(input logic b, output logic s);
        o_sda_oe <= ~b;
        pause();
        o_scl <= 1'b1;
        pause();
        s = i_sda;
        o_scl <= 1'b0;
        pause();
    endtask
    task automatic bus_byte(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bus_bit(d[i], s);
            q[i] = s;
        end
        bus_bit(1'b1, s);
        ack = ~s;
    endtask
endmodule
`default_nettype wire

/* File: dv/seeb_slave_tb.sv */
// self-checking bench for the eeprom bus slave
// assumes the master model in dv and a pull-up on the data wire
`timescale 1ns/1ps
`default_nettype none
module seeb_slave_tb;
    import seeb_pkg::*;
    localparam int TWC = 1000;
    `define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
        $display("CHECK FAILED %s expected %0h seen %0h", nm, (e), (g)); end end
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [2:0] pins = 3'h6;
    logic       wp = 1'b0;
    logic [7:0] peek_addr = 8'h00;
    logic       sda, scl, m_oe, oe, sda_out, busy;
    logic [7:0] peek_data, ptr;
    int         n_errors = 0;
    int         samples_checked = 0;
    always #50 clk = ~clk;
    // a driven one from the device would show on the wire
    assign sda = (oe ? sda_out : 1'b1) & ~m_oe;
    seeb_slave #(.TWC_CYCLES_P(TWC)) i_seeb_slave (
        .i_clock(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(oe),
        .i_chip_select_pin_0(pins[0]), .i_chip_select_pin_1(pins[1]), .i_chip_select_pin_2(pins[2]),
        .i_write_protect(wp), .i_peek_addr(peek_addr), .o_peek_data(peek_data), .o_busy(busy),
        .o_addr_ptr(ptr));
    seeb_master_model i_seeb_master_model (.i_clock(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic send(input logic [7:0] d, input logic e, input string nm);
        logic [7:0] q;
        logic       ack;
        i_seeb_master_model.bus_byte(d, q, ack);
        `CHK(nm, e, ack)
    endtask
    // bursts stay inside one page, except the deliberate wrap test
    task automatic write_seq(input logic [7:0] a, input int n, input logic [7:0] base);
        i_seeb_master_model.bus_start();
        send({DEV_CODE, pins, 1'b0}, 1'b1, "ctrl ack");
        send(a, 1'b1, "addr ack");
        for (int i = 0; i < n; i++) send(base + 8'(i), 1'b1, "data ack");
        i_seeb_master_model.bus_stop();
    endtask
    task automatic wait_idle();
        for (int i = 0; i < TWC + 100 && busy !== 1'b0; i++) @(posedge clk);
        `CHK("busy end", 1'b0, busy)
        tick(8);
    endtask
    task automatic peek(input logic [7:0] a, input logic [7:0] e);
        peek_addr <= a;
        tick(2);
        `CHK("array byte", e, peek_data)
    endtask
    task automatic test_done();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        tick(40000);
        n_errors++;
        test_done();
    end
    initial begin
        logic [7:0] q;
        logic       ack;
        logic       s;
        tick(12);
        rst <= 1'b0;
        tick(8);
        `CHK("oe reset", 1'b0, oe)
        `CHK("busy reset", 1'b0, busy)
        `CHK("ptr reset", PTR_RST, ptr)
        peek(8'h05, 8'hFF);
        // byte write, then a poll while the cycle runs
        write_seq(8'h05, 1, 8'h3C);
        `CHK("busy after stop", 1'b1, busy)
        i_seeb_master_model.bus_start();
        send({DEV_CODE, pins, 1'b0}, 1'b0, "poll nack");
        i_seeb_master_model.bus_stop();
        wait_idle();
        peek(8'h05, 8'h3C);
        for (int cs = 0; cs < 8; cs++) begin
            i_seeb_master_model.bus_start();
            send({DEV_CODE, 3'(cs), 1'b0}, 3'(cs) == pins, "select");
            i_seeb_master_model.bus_stop();
        end
        `CHK("no write cycle", 1'b0, busy)
        i_seeb_master_model.bus_start();
        send({4'hB, pins, 1'b0}, 1'b0, "bad code");
        i_seeb_master_model.bus_start();
        send({DEV_CODE, pins, 1'b1}, 1'b1, "read ctrl");
        i_seeb_master_model.bus_byte(8'hFF, q, ack);
        `CHK("released line", 8'hFF, q)
        i_seeb_master_model.bus_stop();
        // eighteen bytes from 1Eh wrap inside page 10h
        write_seq(8'h1E, 18, 8'h40);
        `CHK("ptr wrap", 8'h10, ptr)
        wait_idle();
        for (int k = 0; k < 16; k++) peek(8'h10 + 8'(k), 8'h42 + 8'(k));
        peek(8'h20, 8'hFF);
        wp <= 1'b1;
        write_seq(8'h85, 1, 8'h77);
        `CHK("protected cycle", 1'b1, busy)
        wait_idle();
        peek(8'h85, 8'hFF);
        write_seq(8'h06, 1, 8'h55);
        wait_idle();
        peek(8'h06, 8'h55);
        wp <= 1'b0;
        // half a data byte, then a fresh start and stop
        i_seeb_master_model.bus_start();
        send({DEV_CODE, pins, 1'b0}, 1'b1, "ctrl ack");
        send(8'h07, 1'b1, "addr ack");
        for (int i = 0; i < 4; i++) i_seeb_master_model.bus_bit(1'b0, s);
        i_seeb_master_model.bus_start();
        i_seeb_master_model.bus_stop();
        tick(20);
        `CHK("abandoned byte", 1'b0, busy)
        `CHK("ptr loaded", 8'h07, ptr)
        peek(8'h07, 8'hFF);
        // full data byte, half a byte, then stop: only the full one is kept
        i_seeb_master_model.bus_start();
        send({DEV_CODE, pins, 1'b0}, 1'b1, "ctrl ack");
        send(8'h0A, 1'b1, "addr ack");
        send(8'h5A, 1'b1, "data ack");
        for (int i = 0; i < 4; i++) i_seeb_master_model.bus_bit(1'b1, s);
        i_seeb_master_model.bus_stop();
        `CHK("cut byte cycle", 1'b1, busy)
        `CHK("ptr after cut", 8'h0B, ptr)
        wait_idle();
        peek(8'h0A, 8'h5A);
        peek(8'h0B, 8'hFF);
        test_done();
    end
endmodule
`default_nettype wire
